// ==== core/transceiver_mode_map.vh ====
// Constants for the transceiver mode controller: mode codes, bias codes and timing counts.
`ifndef TRANSCEIVER_MODE_MAP_VH
`define TRANSCEIVER_MODE_MAP_VH

// ----------------------------------------------------------------------------
// Operating mode encodings
// ----------------------------------------------------------------------------
`define MODE_OFF          2'h0
`define MODE_STANDBY      2'h1
`define MODE_NORMAL       2'h2
`define MODE_OVERTEMP     2'h3

// ----------------------------------------------------------------------------
// Bus bias encodings
// ----------------------------------------------------------------------------
`define BIAS_FLOAT        2'h0
`define BIAS_GROUND       2'h1
`define BIAS_MID          2'h2

// ----------------------------------------------------------------------------
// Timing, in microseconds, and clock rate in MHz
// ----------------------------------------------------------------------------
`define CLK_MHZ           125
`define STARTUP_US        2800
`define SILENCE_US        1000
// Counts are written out sized so they meet the 24-bit counters without truncation.
`define STARTUP_CYCLES    24'h05_5730
`define SILENCE_CYCLES    24'h01_E848
`define COUNT_W           24

`endif

// ==== core/bus_silence_timer.v ====
// Bus silence timer: reports whether the bus has been idle longer than the time-out.
`timescale 1ns/1ps
module bus_silence_timer #(
  parameter [23:0] SILENCE_COUNT = 24'h01_E848
) (
  // Clock and reset.
  input  wire clk_i,
  input  wire resetn_i,
  // Control and bus observation.
  input  wire enable_i,
  input  wire bus_edge_i,
  // Result.
  output reg  silent_o
);

  reg [23:0] count_reg;

  // Any bus edge restarts the count; disabled means the bus counts as silent.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_reg <= 24'h00_0000;
      silent_o  <= 1'b1;
    end else if (!enable_i) begin
      count_reg <= 24'h00_0000;
      silent_o  <= 1'b1;
    end else if (bus_edge_i) begin
      count_reg <= 24'h00_0000;
      silent_o  <= 1'b0;
    end else if (count_reg >= SILENCE_COUNT) begin
      silent_o  <= 1'b1;
    end else begin
      count_reg <= count_reg + 24'h00_0001;
    end
  end

endmodule

// ==== core/transceiver_mode_controller.v ====
// Operating mode controller of a self-supplied bus transceiver.
`timescale 1ns/1ps
`include "transceiver_mode_map.vh"
module transceiver_mode_controller #(
  parameter [23:0] STARTUP_COUNT = `STARTUP_CYCLES,
  parameter [23:0] SILENCE_COUNT = `SILENCE_CYCLES
) (
  // Clock and reset.
  input  wire       CLK_I,
  input  wire       RESETN_I,
  // Host pins.
  input  wire       STANDBY_CTRL_N_I,
  input  wire       TX_DATA_I,
  output reg        RX_DATA_O,
  // Comparator flags.
  input  wire       IO_UNDERVOLTAGE_I,
  input  wire       BATTERY_POWERON_I,
  input  wire       BATTERY_POWEROFF_I,
  input  wire       OVERTEMP_ACTIVATE_I,
  input  wire       OVERTEMP_RELEASE_I,
  // Bus receiver and wake-up detector.
  input  wire       BUS_RX_I,
  input  wire       BUS_EDGE_I,
  input  wire       WAKEUP_PATTERN_I,
  // Analog controls.
  output reg  [1:0] MODE_O,
  output reg  [1:0] BUS_BIAS_O,
  output reg        TX_ENABLE_O,
  output reg        RX_ENABLE_O,
  output reg        SUPPLY_ON_O,
  output reg        BUS_DRIVE_O
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  reg [1:0]  mode_reg;
  reg [1:0]  mode_next;
  reg        booting_reg;
  reg [23:0] boot_count_reg;
  reg        poweron_flag_reg;
  reg        wakeup_flag_reg;
  wire       silent;

  // Bus silence is only watched in Standby.
  bus_silence_timer #(
    .SILENCE_COUNT (SILENCE_COUNT)
  ) u_silence (
    .clk_i         (CLK_I),
    .resetn_i      (RESETN_I),
    .enable_i      (mode_reg == `MODE_STANDBY),
    .bus_edge_i    (BUS_EDGE_I),
    .silent_o      (silent)
  );

  // ----------------------------------------------------------------------------
  // Next mode
  // ----------------------------------------------------------------------------
  // Conditions are tested in priority order so simultaneous events resolve
  // deterministically: power loss outranks heat, which outranks the host.
  always @* begin
    mode_next = mode_reg;
    if (BATTERY_POWEROFF_I) begin
      mode_next = `MODE_OFF;
    end else begin
      case (mode_reg)
        `MODE_OFF: begin
          if (booting_reg && boot_count_reg >= STARTUP_COUNT) begin
            mode_next = `MODE_STANDBY;
          end
        end
        `MODE_STANDBY: begin
          if (OVERTEMP_ACTIVATE_I) begin
            mode_next = `MODE_OVERTEMP;
          end else if (STANDBY_CTRL_N_I && !IO_UNDERVOLTAGE_I) begin
            mode_next = `MODE_NORMAL;
          end
        end
        `MODE_NORMAL: begin
          if (OVERTEMP_ACTIVATE_I) begin
            mode_next = `MODE_OVERTEMP;
          end else if (!STANDBY_CTRL_N_I || IO_UNDERVOLTAGE_I) begin
            mode_next = `MODE_STANDBY;
          end
        end
        `MODE_OVERTEMP: begin
          if (OVERTEMP_RELEASE_I) begin
            mode_next = `MODE_STANDBY;
          end
        end
        default: mode_next = `MODE_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Mode register, start-up timer and indication flags
  // ----------------------------------------------------------------------------
  // The standby control input is active low, so a low level means "stay in standby".
  // The boot counter only runs once the battery is above the power-on level;
  // if the battery sags before start-up completes the initialisation restarts.
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      mode_reg         <= `MODE_OFF;
      booting_reg      <= 1'b0;
      boot_count_reg   <= 24'h00_0000;
      poweron_flag_reg <= 1'b0;
      wakeup_flag_reg  <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      if (mode_reg == `MODE_OFF && !BATTERY_POWEROFF_I && BATTERY_POWERON_I) begin
        booting_reg    <= 1'b1;
        boot_count_reg <= booting_reg ? boot_count_reg + 24'h00_0001 : 24'h00_0000;
      end else begin
        booting_reg    <= 1'b0;
        boot_count_reg <= 24'h00_0000;
      end
      // Power-on indication: set on leaving Off, held until Normal or a return to Off.
      if (mode_reg == `MODE_OFF && mode_next == `MODE_STANDBY) begin
        poweron_flag_reg <= 1'b1;
      end else if (mode_next == `MODE_NORMAL || mode_next == `MODE_OFF) begin
        poweron_flag_reg <= 1'b0;
      end
      // Wake-up indication: detected only in Standby, survives Overtemp.
      if (mode_reg == `MODE_STANDBY && WAKEUP_PATTERN_I && mode_next != `MODE_OFF) begin
        wakeup_flag_reg <= 1'b1;
      end else if (mode_next == `MODE_NORMAL || mode_next == `MODE_OFF) begin
        wakeup_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------------
  // Outputs follow the next mode so they change in the same edge as the mode.
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      MODE_O      <= `MODE_OFF;
      BUS_BIAS_O  <= `BIAS_FLOAT;
      TX_ENABLE_O <= 1'b0;
      RX_ENABLE_O <= 1'b0;
      SUPPLY_ON_O <= 1'b0;
      BUS_DRIVE_O <= 1'b0;
      RX_DATA_O   <= 1'b1;
    end else begin
      MODE_O <= mode_next;
      case (mode_next)
        `MODE_NORMAL: begin
          BUS_BIAS_O  <= `BIAS_MID;
          TX_ENABLE_O <= 1'b1;
          RX_ENABLE_O <= 1'b1;
          SUPPLY_ON_O <= 1'b1;
          BUS_DRIVE_O <= ~TX_DATA_I;
          RX_DATA_O   <= BUS_RX_I;
        end
        `MODE_STANDBY: begin
          BUS_BIAS_O  <= silent ? `BIAS_GROUND : `BIAS_MID;
          TX_ENABLE_O <= 1'b0;
          RX_ENABLE_O <= 1'b0;
          SUPPLY_ON_O <= wakeup_flag_reg | (mode_reg == `MODE_STANDBY & WAKEUP_PATTERN_I);
          BUS_DRIVE_O <= 1'b0;
          // A fresh wake-up is reported in the very cycle it is latched.
          RX_DATA_O   <= ~(poweron_flag_reg | wakeup_flag_reg | (mode_reg == `MODE_OFF)
                           | (mode_reg == `MODE_STANDBY & WAKEUP_PATTERN_I));
        end
        `MODE_OVERTEMP: begin
          BUS_BIAS_O  <= `BIAS_FLOAT;
          TX_ENABLE_O <= 1'b0;
          RX_ENABLE_O <= 1'b0;
          SUPPLY_ON_O <= 1'b0;
          BUS_DRIVE_O <= 1'b0;
          RX_DATA_O   <= ~(poweron_flag_reg | wakeup_flag_reg
                           | (mode_reg == `MODE_STANDBY & WAKEUP_PATTERN_I));
        end
        default: begin
          BUS_BIAS_O  <= `BIAS_FLOAT;
          TX_ENABLE_O <= 1'b0;
          RX_ENABLE_O <= 1'b0;
          SUPPLY_ON_O <= 1'b0;
          BUS_DRIVE_O <= 1'b0;
          RX_DATA_O   <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ==== verif/host_model.sv ====
// Host model that drives the standby control pin from a wanted mode.
`timescale 1ns/1ps
module host_model (
  // Clock and wanted mode.
  input  wire clk_i,
  input  wire want_normal_i,
  // Standby control pin; low asks for Standby.
  output reg  standby_ctrl_n_o
);
  // The pin moves just after an edge, like a real port, so it costs a cycle.
  initial standby_ctrl_n_o = 1'b0;
  always @(posedge clk_i) begin
    standby_ctrl_n_o <= want_normal_i;
  end
endmodule

// ==== verif/tmc_asserts.sv ====
// Checker for the operating mode controller ports.
`timescale 1ns/1ps
`include "transceiver_mode_map.vh"
module tmc_checker (
  // Watched ports.
  input wire       CLK_I,
  input wire       RESETN_I,
  input wire       STANDBY_CTRL_N_I,
  input wire       IO_UNDERVOLTAGE_I,
  input wire       BATTERY_POWEROFF_I,
  input wire       OVERTEMP_ACTIVATE_I,
  input wire       OVERTEMP_RELEASE_I,
  input wire       BUS_RX_I,
  input wire       WAKEUP_PATTERN_I,
  input wire       RX_DATA_O,
  input wire [1:0] MODE_O,
  input wire [1:0] BUS_BIAS_O,
  input wire       TX_ENABLE_O,
  input wire       RX_ENABLE_O,
  input wire       SUPPLY_ON_O
);
  // Higher-priority events absent, and a valid request for Normal.
  wire calm = !BATTERY_POWEROFF_I && !OVERTEMP_ACTIVATE_I;
  wire go   = STANDBY_CTRL_N_I && !IO_UNDERVOLTAGE_I;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_pon; MODE_O == `MODE_OFF ##1 MODE_O == `MODE_STANDBY; endsequence
  sequence s_wake; MODE_O == `MODE_STANDBY && WAKEUP_PATTERN_I && calm && !go; endsequence
  property p_off; BATTERY_POWEROFF_I |=> MODE_O == `MODE_OFF; endproperty
  a_off: assert property (p_off) else $error("off not entered");
  property p_otp; (MODE_O == `MODE_STANDBY || MODE_O == `MODE_NORMAL)
    && OVERTEMP_ACTIVATE_I && !BATTERY_POWEROFF_I |=> MODE_O == `MODE_OVERTEMP; endproperty
  a_otp: assert property (p_otp) else $error("overtemp not entered");
  property p_go; MODE_O == `MODE_STANDBY && go && calm |=> MODE_O == `MODE_NORMAL; endproperty
  a_go: assert property (p_go) else $error("normal not entered");
  property p_back; MODE_O == `MODE_NORMAL && !go && calm |=> MODE_O == `MODE_STANDBY; endproperty
  a_back: assert property (p_back) else $error("standby not entered");
  property p_rel; MODE_O == `MODE_OVERTEMP && OVERTEMP_RELEASE_I && !BATTERY_POWEROFF_I
    |=> MODE_O == `MODE_STANDBY; endproperty
  a_rel: assert property (p_rel) else $error("overtemp not left");
  property p_pon; s_pon |-> !RX_DATA_O; endproperty
  a_pon: assert property (p_pon) else $error("power-on not shown");
  property p_wake; s_wake |=> !RX_DATA_O && SUPPLY_ON_O; endproperty
  a_wake: assert property (p_wake) else $error("wake-up not shown");
  property p_hold; !RX_DATA_O && MODE_O != `MODE_NORMAL && MODE_O != `MODE_OFF
    && !STANDBY_CTRL_N_I && !BATTERY_POWEROFF_I |=> !RX_DATA_O; endproperty
  a_hold: assert property (p_hold) else $error("indication lost");
  property p_quiet; MODE_O != `MODE_NORMAL |-> !TX_ENABLE_O && !RX_ENABLE_O; endproperty
  a_quiet: assert property (p_quiet) else $error("paths enabled");
  property p_float; (MODE_O == `MODE_OFF || MODE_O == `MODE_OVERTEMP)
    |-> BUS_BIAS_O == `BIAS_FLOAT && !SUPPLY_ON_O; endproperty
  a_float: assert property (p_float) else $error("bus not floating");
  property p_rx; MODE_O == `MODE_NORMAL |-> RX_DATA_O == $past(BUS_RX_I); endproperty
  a_rx: assert property (p_rx) else $error("rx not following bus");
endmodule
bind transceiver_mode_controller tmc_checker u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
  .STANDBY_CTRL_N_I(STANDBY_CTRL_N_I), .IO_UNDERVOLTAGE_I(IO_UNDERVOLTAGE_I),
  .BATTERY_POWEROFF_I(BATTERY_POWEROFF_I), .OVERTEMP_ACTIVATE_I(OVERTEMP_ACTIVATE_I),
  .OVERTEMP_RELEASE_I(OVERTEMP_RELEASE_I), .BUS_RX_I(BUS_RX_I),
  .WAKEUP_PATTERN_I(WAKEUP_PATTERN_I), .RX_DATA_O(RX_DATA_O), .MODE_O(MODE_O),
  .BUS_BIAS_O(BUS_BIAS_O), .TX_ENABLE_O(TX_ENABLE_O), .RX_ENABLE_O(RX_ENABLE_O),
  .SUPPLY_ON_O(SUPPLY_ON_O));

// ==== verif/tb_top.sv ====
// Self-checking testbench for the operating mode controller.
`timescale 1ns/1ps
`include "transceiver_mode_map.vh"
module tb_top;
  // Short counts keep the run brief; expectations derive from them.
  localparam [23:0] SU = 24'h00_0014;
  localparam [23:0] SI = 24'h00_000A;
  reg clk = 1'b0, rstn = 1'b0, want = 1'b0, txd = 1'b1, uv = 1'b0, pon = 1'b0;
  reg poff = 1'b0, otp = 1'b0, rel = 1'b0, brx = 1'b1, bedge = 1'b0, wake = 1'b0;
  wire       standby_ctrl_n, rxd, txe, rxe, sup, drv;
  wire [1:0] mode, bias;
  integer    err_count = 0, tests_run = 0;
  always #4 clk = ~clk;
  host_model u_host (.clk_i(clk), .want_normal_i(want), .standby_ctrl_n_o(standby_ctrl_n));
  transceiver_mode_controller #(.STARTUP_COUNT(SU), .SILENCE_COUNT(SI)) DUT (
    .CLK_I(clk), .RESETN_I(rstn), .STANDBY_CTRL_N_I(standby_ctrl_n), .TX_DATA_I(txd),
    .RX_DATA_O(rxd), .IO_UNDERVOLTAGE_I(uv), .BATTERY_POWERON_I(pon),
    .BATTERY_POWEROFF_I(poff), .OVERTEMP_ACTIVATE_I(otp), .OVERTEMP_RELEASE_I(rel),
    .BUS_RX_I(brx), .BUS_EDGE_I(bedge), .WAKEUP_PATTERN_I(wake), .MODE_O(mode),
    .BUS_BIAS_O(bias), .TX_ENABLE_O(txe), .RX_ENABLE_O(rxe), .SUPPLY_ON_O(sup),
    .BUS_DRIVE_O(drv));
  task chk(input [79:0] name, input [23:0] seen, input [23:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Step past n edges; the extra 1 ns lets registered outputs settle.
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task power_up;
    integer n;
    begin
      @(posedge clk) pon <= 1'b1;
      tick(1);
      for (n = 0; mode !== `MODE_STANDBY && n < 40; n = n + 1) tick(1);
      // The count runs from the edge after the one that first samples power-on.
      chk("startup", n[23:0], SU + 24'h00_0001);
      chk("rx_pon", rxd, 1'b0);
      chk("bias", bias, `BIAS_GROUND);
    end
  endtask
  task normal_path;
    begin
      @(posedge clk) uv <= 1'b1;
      want <= 1'b1;
      tick(3);
      chk("uv_block", mode, `MODE_STANDBY);
      @(posedge clk) uv <= 1'b0;
      tick(1);
      chk("enables", {mode, txe, rxe}, {`MODE_NORMAL, 2'b11});
      @(posedge clk) brx <= 1'b0;
      txd <= 1'b0;
      tick(1);
      chk("rx_drive", {rxd, drv}, 2'b01);
      @(posedge clk) uv <= 1'b1;
      tick(1);
      chk("uv_drop", {mode, rxd, txe}, {`MODE_STANDBY, 2'b10});
      @(posedge clk) uv <= 1'b0;
      tick(1);
      chk("renormal", mode, `MODE_NORMAL);
      // The host pin lags one edge, so Standby follows two edges later.
      @(posedge clk) want <= 1'b0;
      tick(2);
      chk("stby", mode, `MODE_STANDBY);
    end
  endtask
  task wake_heat;
    begin
      @(posedge clk) bedge <= 1'b1;
      @(posedge clk) bedge <= 1'b0;
      tick(1);
      chk("bias_mid", bias, `BIAS_MID);
      tick(SI + 3);
      chk("bias_gnd", bias, `BIAS_GROUND);
      @(posedge clk) wake <= 1'b1;
      @(posedge clk) wake <= 1'b0;
      tick(1);
      chk("wake", {rxd, sup}, 2'b01);
      @(posedge clk) otp <= 1'b1;
      tick(1);
      chk("otp", {mode, bias, sup, rxd}, {`MODE_OVERTEMP, `BIAS_FLOAT, 2'b00});
      @(posedge clk) otp <= 1'b0;
      rel <= 1'b1;
      tick(1);
      chk("release", {mode, rxd}, {`MODE_STANDBY, 1'b0});
      @(posedge clk) rel <= 1'b0;
    end
  endtask
  task priority_mix;
    begin
      @(posedge clk) want <= 1'b1;
      tick(3);
      @(posedge clk) uv <= 1'b1;
      otp <= 1'b1;
      tick(1);
      chk("pri_otp", mode, `MODE_OVERTEMP);
      @(posedge clk) poff <= 1'b1;
      rel <= 1'b1;
      tick(1);
      chk("pri_off", {mode, bias, rxd}, {`MODE_OFF, `BIAS_FLOAT, 1'b1});
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // A hang is judged a mismatch; the tests need well under 2 us.
  initial begin
    #20000;
    err_count = err_count + 1;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    power_up;
    normal_path;
    wake_heat;
    priority_mix;
    report_and_stop;
  end
endmodule
